// ### src/i2c_slave_data.sv
// Two-wire bus slave: data phase, acknowledge, clock hold and bus time-out.
// How it works
// - Bytes are eight bits, MSB first.
// - Receiver acknowledges low after each byte while acknowledge control is zero.
// - No master acknowledge: release data line.
// - Bytes pass through the data buffer.
// - Receiver drives acknowledge on ninth clock.
// - Received acknowledge decides next transmit byte.
// - Hold clock low until buffer serviced.
// - Start on match; clock fall clears count.
// - Time-out when period passes without fall.
// - Stop condition halts time-out counting.
// - Overflow halts counter, clears enable, sets flag.
// - Time-out raises the serial interrupt request.
// - Time-out resets sequencer and second control.
// - Time-out flag stays until software clears.
// - Period is (select plus one) times 32.
// - Request flag bit 4, enable bit 0.
// - Acknowledge control zero drives low, one leaves high.
// - Received acknowledge reads zero when master acknowledged.
// - Direction bit: one transmits, zero receives.
`timescale 1ns/100ps
module i2c_slave_data
   import i2c_slave_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RSTN,
   input  wire logic        I_CE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_SCL,
   output logic             O_SCL_OUT,
   output logic             O_SCL_OE,
   input  wire logic        I_SDA,
   output logic             O_SDA_OUT,
   output logic             O_SDA_OE,
   input  wire logic        I_SUB_CLK,
   output logic             O_IRQ
);

   typedef struct packed {
      logic                 scl_m, scl_s, scl_p;
      logic                 sda_m, sda_s, sda_p;
      logic                 sub_m, sub_s, sub_p;
      state_t               fsm;
      logic [3:0]           bitcnt;
      logic [7:0]           shift;
      logic [7:0]           tx_shift;
      logic [7:0]           data_buf;
      logic [6:0]           slv_addr;
      logic [7:0]           ctrl0;
      logic                 dir, txack, rxack, srw, matched, busy;
      logic                 toc_en, toc_flag;
      logic [TOC_SEL_W-1:0] toc_sel;
      logic                 irq_f, irq_e, irq;
      logic                 scl_oe, sda_oe, line_lo;
      logic [31:0]          prdata;
      logic                 pready, pslverr;
   } st_t;

   st_t  q;
   st_t  d;
   logic rst_meta_q;
   logic rst_n_q;
   logic scl_rise, scl_fall, start_c, stop_c, sub_tick;
   logic acc, wr, rd, sw_service, match_evt, to_expired;

   // ==========================================================================
   // Register decoding helpers.
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFS_DATA) || (a == OFS_ADDR) || (a == OFS_CTRL0) ||
                  (a == OFS_CTRL1) || (a == OFS_TOC) || (a == OFS_INTERRUPT_CONTROL_ONE);
   endfunction : is_mapped

   function automatic logic [7:0] reg_read(input logic [7:0] a, input st_t s);
      reg_read = REG_POR;
      case (a)
         OFS_DATA:  reg_read = s.data_buf;
         OFS_ADDR:  reg_read = {1'h0, s.slv_addr};
         OFS_CTRL0: reg_read = s.ctrl0;
         OFS_CTRL1: begin
            reg_read[C1_RX_ACK_STATUS_BIT] = s.rxack;
            reg_read[C1_SRW_BIT]  = s.srw;
            reg_read[C1_TX_ACK_CONTROL_BIT] = s.txack;
            reg_read[C1_DIR_BIT]  = s.dir;
            reg_read[C1_BUSY_BIT] = s.busy;
            reg_read[C1_MTCH_BIT] = s.matched;
         end
         OFS_TOC:   reg_read = {s.toc_en, s.toc_flag, s.toc_sel};
         OFS_INTERRUPT_CONTROL_ONE: begin
            reg_read[IRQF_BIT] = s.irq_f;
            reg_read[IRQE_BIT] = s.irq_e;
         end
         default:   reg_read = REG_POR;
      endcase
   endfunction : reg_read

   // ==========================================================================
   // Reset release through two flip-flops.
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_meta_q <= 1'h0;
         rst_n_q    <= 1'h0;
      end else begin
         rst_meta_q <= 1'h1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Bus event detection on the synchronised pin copies.
   assign scl_rise  = q.scl_s & ~q.scl_p;
   assign scl_fall  = ~q.scl_s & q.scl_p;
   assign start_c   = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop_c    = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
   assign sub_tick  = q.sub_s & ~q.sub_p;
   assign acc       = I_PSEL & I_PENABLE;
   assign wr        = acc & q.pready & I_PWRITE & is_mapped(I_PADDR);
   assign rd        = acc & q.pready & ~I_PWRITE;
   assign match_evt = (q.fsm == ST_ADDR) && !start_c && !stop_c && scl_fall &&
                      (q.bitcnt == BITS_PER_BYTE) && q.ctrl0[C0_EN_BIT] &&
                      (q.shift[7:1] == q.slv_addr);
   // Software service: write in transmit mode, dummy read in receive mode.
   assign sw_service = (I_PADDR == OFS_DATA) &&
                       ((wr && q.dir) || (rd && !q.dir));

   // ==========================================================================
   // Time-out timer.
   i2c_timeout_timer u_timer (
      .i_clk      (I_CLK),
      .i_rst_n    (rst_n_q),
      .i_ce       (I_CE),
      .i_enable   (q.toc_en),
      .i_start    (match_evt),
      .i_scl_fall (scl_fall),
      .i_stop     (stop_c),
      .i_sub_tick (sub_tick),
      .i_sel      (q.toc_sel),
      .o_expired  (to_expired)
   );

   // ==========================================================================
   // Next state: synchronisers, bus slave, sequencer and time-out effects.
   always_comb begin
      d       = q;
      d.scl_m = I_SCL;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = I_SDA;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.sub_m = I_SUB_CLK;
      d.sub_s = q.sub_m;
      d.sub_p = q.sub_s;
      d.line_lo = 1'h0;
      // Register bus: one wait state, data and error prepared for the answer.
      d.pready = acc & ~q.pready;
      if (acc && !q.pready) begin
         d.prdata  = {24'h000000, reg_read(I_PADDR, q)};
         d.pslverr = ~is_mapped(I_PADDR);
      end
      if (wr) begin
         case (I_PADDR)
            OFS_DATA:  d.data_buf = I_PWDATA[7:0];
            OFS_ADDR:  d.slv_addr = I_PWDATA[6:0];
            OFS_CTRL0: d.ctrl0    = I_PWDATA[7:0];
            OFS_CTRL1: begin
               d.dir   = I_PWDATA[C1_DIR_BIT];
               d.txack = I_PWDATA[C1_TX_ACK_CONTROL_BIT];
            end
            OFS_TOC: begin
               d.toc_en   = I_PWDATA[TOC_EN_BIT];
               d.toc_flag = I_PWDATA[TOC_FLG_BIT];
               d.toc_sel  = I_PWDATA[TOC_SEL_W-1:0];
            end
            OFS_INTERRUPT_CONTROL_ONE: begin
               d.irq_f = I_PWDATA[IRQF_BIT];
               d.irq_e = I_PWDATA[IRQE_BIT];
            end
            default: d.ctrl0 = q.ctrl0;
         endcase
      end
      // Bus conditions override every state; hardware sets win over writes.
      if (start_c) begin
         d.fsm     = ST_ADDR;
         d.bitcnt  = '0;
         d.busy    = 1'h1;
         d.matched = 1'h0;
         d.sda_oe  = 1'h0;
         d.scl_oe  = 1'h0;
      end else if (stop_c) begin
         d.fsm     = ST_IDLE;
         d.busy    = 1'h0;
         d.matched = 1'h0;
         d.sda_oe  = 1'h0;
         d.scl_oe  = 1'h0;
      end else begin
         case (q.fsm)
            ST_IDLE: d.fsm = ST_IDLE;
            ST_ADDR: begin
               if (scl_rise) begin
                  d.shift  = {q.shift[6:0], q.sda_s};
                  d.bitcnt = q.bitcnt + BIT_STEP;
               end
               if (scl_fall && q.bitcnt == BITS_PER_BYTE) begin
                  if (match_evt) begin
                     d.srw     = q.shift[0];
                     d.matched = 1'h1;
                     d.irq_f   = 1'h1;
                     d.sda_oe  = 1'h1;
                     d.fsm     = ST_ADDR_ACK;
                  end else begin
                     d.fsm = ST_WAIT_STOP;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'h0;
                  d.scl_oe = 1'h1;
                  d.fsm    = ST_HOLD;
               end
            end
            ST_HOLD: begin
               d.scl_oe = 1'h1;
               if (sw_service) begin
                  d.scl_oe   = 1'h0;
                  d.bitcnt   = '0;
                  d.tx_shift = d.data_buf;
                  d.sda_oe   = q.dir & ~d.data_buf[7];
                  d.fsm      = ST_DATA;
               end
            end
            ST_DATA: begin
               if (scl_rise) begin
                  d.shift  = {q.shift[6:0], q.sda_s};
                  d.bitcnt = q.bitcnt + BIT_STEP;
               end
               if (scl_fall) begin
                  if (q.bitcnt == BITS_PER_BYTE) begin
                     if (q.dir) begin
                        d.sda_oe = 1'h0;
                     end else begin
                        d.data_buf = q.shift;
                        d.sda_oe   = ~q.txack;
                     end
                     d.fsm = ST_DATA_ACK;
                  end else if (q.dir) begin
                     d.tx_shift = {q.tx_shift[6:0], 1'h0};
                     d.sda_oe   = ~q.tx_shift[6];
                  end
               end
            end
            ST_DATA_ACK: begin
               if (scl_rise && q.dir) begin
                  d.rxack = q.sda_s;
               end
               if (scl_fall) begin
                  d.sda_oe = 1'h0;
                  d.irq_f  = 1'h1;
                  if (q.dir ? q.rxack : q.txack) begin
                     d.fsm = ST_WAIT_STOP;
                  end else begin
                     d.scl_oe = 1'h1;
                     d.fsm    = ST_HOLD;
                  end
               end
            end
            ST_WAIT_STOP: begin
               d.sda_oe = 1'h0;
               d.scl_oe = 1'h0;
            end
            default: d.fsm = ST_IDLE;
         endcase
      end
      // Time-out: flag, request and sequencer reset.
      if (to_expired) begin
         d.toc_en   = 1'h0;
         d.toc_flag = 1'h1;
         d.irq_f    = 1'h1;
         d.fsm      = ST_IDLE;
         d.bitcnt   = '0;
         d.sda_oe   = 1'h0;
         d.scl_oe   = 1'h0;
         d.busy     = 1'h0;
         d.dir      = CTRL1_POR[C1_DIR_BIT];
         d.txack    = CTRL1_POR[C1_TX_ACK_CONTROL_BIT];
         d.rxack    = CTRL1_POR[C1_RX_ACK_STATUS_BIT];
         d.srw      = CTRL1_POR[C1_SRW_BIT];
         d.matched  = CTRL1_POR[C1_MTCH_BIT];
      end
      d.irq = d.irq_f & d.irq_e;
   end

   // State register; clock enable freezes everything.
   always_ff @(posedge I_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q <= '0;
      end else if (I_CE) begin
         q <= d;
      end
   end

   assign O_PRDATA  = q.prdata;
   assign O_PREADY  = q.pready;
   assign O_PSLVERR = q.pslverr;
   assign O_SCL_OUT = q.line_lo;
   assign O_SCL_OE  = q.scl_oe;
   assign O_SDA_OUT = q.line_lo;
   assign O_SDA_OE  = q.sda_oe;
   assign O_IRQ     = q.irq;

   // ==========================================================================
   // Checks.
   chk_tx_msb_first: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && q.fsm == ST_HOLD && sw_service && q.dir && !start_c && !stop_c
       && !to_expired) |=> (O_SDA_OE == !$past(I_PWDATA[7])) && !O_SCL_OE)
      else $error("First transmit bit is not the buffer MSB.");

   chk_rx_ack_drive: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && q.fsm == ST_DATA && !q.dir && scl_fall && q.bitcnt == BITS_PER_BYTE
       && !start_c && !stop_c && !to_expired)
      |=> (q.fsm == ST_DATA_ACK) && (O_SDA_OE == !$past(q.txack)))
      else $error("Acknowledge level does not follow its control flag.");

   chk_nack_release: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (q.fsm == ST_WAIT_STOP) |-> !O_SDA_OE && !O_SCL_OE)
      else $error("Data line driven after a missing acknowledge.");

   chk_hold_clock: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && q.fsm == ST_HOLD && !sw_service && !start_c && !stop_c
       && !to_expired) |=> O_SCL_OE && q.fsm == ST_HOLD)
      else $error("Clock line released before the buffer was serviced.");

   chk_expire_flags: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && to_expired) |=> !q.toc_en && q.toc_flag)
      else $error("Time-out did not clear enable and set its flag.");

   chk_expire_irq: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && to_expired) |=> q.irq_f ##1 (O_IRQ == q.irq_e))
      else $error("Time-out did not raise the serial request.");

   chk_expire_reset: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && to_expired) |=> q.fsm == ST_IDLE && !q.dir && !q.txack && !O_SCL_OE
       && q.slv_addr == $past(q.slv_addr))
      else $error("Time-out did not return the sequencer to its reset state.");

   chk_flag_sticky: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && q.toc_flag && !(wr && I_PADDR == OFS_TOC)) |=> q.toc_flag)
      else $error("Time-out flag dropped without a software write.");

   chk_rxack_sample: assert property (
      @(posedge I_CLK) disable iff (!rst_n_q)
      (I_CE && q.fsm == ST_DATA_ACK && q.dir && scl_rise && !start_c && !stop_c
       && !to_expired) |=> q.rxack == $past(q.sda_s))
      else $error("Received acknowledge not taken from the data line.");

endmodule : i2c_slave_data

// ### src/i2c_slave_pkg.sv
// Constants and types shared by the two-wire slave and its time-out timer.
package i2c_slave_pkg;

   // ==========================================================================
   // Register offsets on the register bus (byte addresses).
   localparam logic [7:0] OFS_DATA  = 8'h00;
   localparam logic [7:0] OFS_ADDR  = 8'h04;
   localparam logic [7:0] OFS_CTRL0 = 8'h08;
   localparam logic [7:0] OFS_CTRL1 = 8'h0C;
   localparam logic [7:0] OFS_TOC   = 8'h10;
   localparam logic [7:0] OFS_INTERRUPT_CONTROL_ONE = 8'h14;

   // ==========================================================================
   // Field positions.
   localparam int C0_EN_BIT   = 0;
   localparam int C1_RX_ACK_STATUS_BIT = 0;
   localparam int C1_SRW_BIT  = 2;
   localparam int C1_TX_ACK_CONTROL_BIT = 3;
   localparam int C1_DIR_BIT  = 4;
   localparam int C1_BUSY_BIT = 5;
   localparam int C1_MTCH_BIT = 6;
   localparam int TOC_EN_BIT  = 7;
   localparam int TOC_FLG_BIT = 6;
   localparam int TOC_SEL_W   = 6;
   localparam int IRQF_BIT    = 4;
   localparam int IRQE_BIT    = 0;

   // ==========================================================================
   // Reset values and counts.
   localparam logic [7:0] REG_POR       = 8'h00;
   localparam logic [7:0] CTRL1_POR     = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_STEP      = 4'h1;
   // The time-out ticks at the sub clock divided by this power of two.
   localparam int         SUB_DIV_LOG2  = 5;
   localparam int         TO_CNT_W      = TOC_SEL_W + SUB_DIV_LOG2;
   localparam logic [SUB_DIV_LOG2-1:0] SUB_DIV_LAST = 5'h1F;
   localparam logic [TO_CNT_W-1:0]     TO_CNT_STEP  = 11'h001;

   // ==========================================================================
   // Bus sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_HOLD,
      ST_DATA,
      ST_DATA_ACK,
      ST_WAIT_STOP
   } state_t;

endpackage : i2c_slave_pkg

// ### src/i2c_timeout_timer.sv
// Bus time-out timer counting divided sub clock ticks between clock falls.
`timescale 1ns/100ps
module i2c_timeout_timer
   import i2c_slave_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_ce,
   input  wire logic                 i_enable,
   input  wire logic                 i_start,
   input  wire logic                 i_scl_fall,
   input  wire logic                 i_stop,
   input  wire logic                 i_sub_tick,
   input  wire logic [TOC_SEL_W-1:0] i_sel,
   output logic                      o_expired
);

   typedef struct packed {
      logic                run;
      logic [TO_CNT_W-1:0] cnt;
      logic                expired;
   } tmr_t;

   tmr_t q;
   tmr_t d;
   logic [TO_CNT_W-1:0] limit;

   // ==========================================================================
   // Counting, clearing and overflow.
   always_comb begin
      d         = q;
      d.expired = 1'h0;
      limit     = {i_sel, SUB_DIV_LAST};
      if (!i_enable) begin
         d.run = 1'h0;
         d.cnt = '0;
      end else if (i_stop) begin
         d.run = 1'h0;
         d.cnt = '0;
      end else if (i_start) begin
         d.run = 1'h1;
         d.cnt = '0;
      end else if (q.run) begin
         if (i_scl_fall) begin
            d.cnt = '0;
         end else if (i_sub_tick) begin
            if (q.cnt == limit) begin
               d.expired = 1'h1;
               d.run     = 1'h0;
            end else begin
               d.cnt = q.cnt + TO_CNT_STEP;
            end
         end
      end
   end

   // State register.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_expired = q.expired;

   // ==========================================================================
   // Checks.
   chk_idle_disabled: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !i_enable) |=> (q.cnt == '0 && !q.run && !q.expired))
      else $error("Timer not idle while disabled.");

   chk_stop_halts: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && i_stop) |=> !q.run ##1 !q.expired)
      else $error("Timer kept running after a stop.");

endmodule : i2c_timeout_timer

// ### test/i2c_master_model.sv
// Behavioural two-wire bus master that pulls the open-drain lines low.
`timescale 1ns/100ps
module i2c_master_model (
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_low,
   output logic      o_sda_low
);
   // ==========================================================================
   // Both lines start released, so the pull-ups hold them high.
   initial begin
      o_scl_low = 1'h0;
      o_sda_low = 1'h0;
   end

   // One clock: data set while low, sampled mid high; a held clock is waited out.
   // Lines change by non-blocking assignment, so a change on a clock edge lands after it.
   task automatic bit_io(input logic b, output logic s);
      o_sda_low <= !b;
      #100;
      o_scl_low <= 1'h0;
      wait (i_scl === 1'h1);
      #100;
      s = i_sda;
      #100;
      o_scl_low <= 1'h1;
      #100;
   endtask : bit_io

   // Start: data falls while the clock is high.
   task automatic start_c();
      o_sda_low <= 1'h1;
      #200;
      o_scl_low <= 1'h1;
      #100;
   endtask : start_c

   // Stop: data rises while the clock is high.
   task automatic stop_c();
      o_sda_low <= 1'h1;
      #100;
      o_scl_low <= 1'h0;
      wait (i_scl === 1'h1);
      #200;
      o_sda_low <= 1'h0;
      #200;
   endtask : stop_c

   // Sends a byte MSB first and returns the level seen on the ninth clock.
   task automatic put_byte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], ack);
      bit_io(1'h1, ack);
   endtask : put_byte

   // Reads a byte MSB first, then drives low to acknowledge or leaves it high.
   task automatic get_byte(input logic nack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(1'h1, d[i]);
      bit_io(nack, s);
   endtask : get_byte
endmodule : i2c_master_model

// ### test/i2c_slave_data_tb.sv
// Self-checking bench for the two-wire slave data phase and time-out.
`timescale 1ns/100ps
module i2c_slave_data_tb
   import i2c_slave_pkg::*;
;
   logic        clk, rst_n, sub_clk, psel, penable, pwrite, ack, er;
   logic        pready, pslverr, scl_oe, sda_oe, irq, m_scl, m_sda;
   logic        scl_out, sda_out;
   logic [7:0]  paddr, b;
   logic [31:0] pwdata, prdata, rv;
   wire         scl_w, sda_w;
   int          error_cnt, checks_done, cyc, n;

   // ==========================================================================
   // Wired-AND lines with pull-ups, clocks and the run-time ceiling.
   // The design pulls a line only when it drives a low level with its enable.
   assign scl_w = !(m_scl | (scl_oe & !scl_out));
   assign sda_w = !(m_sda | (sda_oe & !sda_out));
   always #25 clk = ~clk;
   always #100 sub_clk = ~sub_clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         print_verdict();
      end
   end

   i2c_master_model m (.i_scl(scl_w), .i_sda(sda_w), .o_scl_low(m_scl), .o_sda_low(m_sda));
   i2c_slave_data DUT (.I_CLK(clk), .I_RSTN(rst_n), .I_CE(1'h1), .I_PADDR(paddr),
      .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_SCL(scl_w),
      .O_SCL_OUT(scl_out), .O_SCL_OE(scl_oe), .I_SDA(sda_w), .O_SDA_OUT(sda_out),
      .O_SDA_OE(sda_oe), .I_SUB_CLK(sub_clk), .O_IRQ(irq));

   // ==========================================================================
   // One APB transfer; the request holds until pready is seen at an edge.
   // Only the run ceiling ends a wait that never gets its answer.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'h1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
      end while (pready !== 1'h1);
      rv = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // Compares one value and reports a mismatch at once.
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk

   // Register read with an optional mask, and register write.
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s,
                     input logic [31:0] k = 32'hFFFF_FFFF);
      apb(1'h0, a, 32'h0);
      chk(s, e, rv & k);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'h1, a, {24'h0, d});
   endtask : wr

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   // ==========================================================================
   // Main sequence.
   initial begin
      {clk, rst_n, sub_clk, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      rd(OFS_TOC, 32'h0, "toc_por");
      rd(OFS_INTERRUPT_CONTROL_ONE, 32'h0, "interrupt_control_one_por");
      rd(OFS_CTRL1, 32'h0, "ctrl1_por");
      rd(8'h18, 32'h0, "unmapped");
      chk("pslverr", 32'h1, er);
      wr(OFS_INTERRUPT_CONTROL_ONE, 8'hFF);
      rd(OFS_INTERRUPT_CONTROL_ONE, 32'h11, "interrupt_control_one_bits");
      chk("irq_on", 32'h1, irq);
      wr(OFS_INTERRUPT_CONTROL_ONE, 8'h10);
      rd(OFS_INTERRUPT_CONTROL_ONE, 32'h10, "flag_only");
      chk("irq_mask", 32'h0, irq);
      wr(OFS_INTERRUPT_CONTROL_ONE, 8'h01);
      wr(OFS_CTRL0, 8'h01);
      wr(OFS_ADDR, 8'h5A);
      $display("Test registers done");
      m.start_c();
      m.put_byte(8'h12, ack);
      chk("no_match", 32'h1, ack);
      chk("no_match_irq", 32'h0, irq);
      m.stop_c();
      m.start_c();
      m.put_byte(8'hB4, ack);
      chk("addr_ack", 32'h0, ack);
      chk("irq_match", 32'h1, irq);
      wr(OFS_INTERRUPT_CONTROL_ONE, 8'h01);
      chk("hold", 32'h1, scl_oe);
      apb(1'h0, OFS_DATA, 32'h0);
      m.put_byte(8'hC3, ack);
      chk("data_ack", 32'h0, ack);
      wr(OFS_CTRL1, 8'h08);
      rd(OFS_DATA, 32'hC3, "rx_byte");
      m.put_byte(8'h3C, ack);
      chk("nack", 32'h1, ack);
      m.stop_c();
      rd(OFS_TOC, 32'h0, "toc_idle");
      $display("Test receive done");
      m.start_c();
      m.put_byte(8'hB5, ack);
      chk("raddr_ack", 32'h0, ack);
      rd(OFS_CTRL1, 32'h4, "srw", 32'h4);
      wr(OFS_CTRL1, 8'h10);
      wr(OFS_DATA, 8'hA5);
      m.get_byte(1'h0, b);
      chk("tx1", 32'hA5, b);
      rd(OFS_CTRL1, 32'h10, "rxak0", 32'h11);
      wr(OFS_DATA, 8'h5C);
      m.get_byte(1'h1, b);
      chk("tx2", 32'h5C, b);
      rd(OFS_CTRL1, 32'h11, "rxak1", 32'h11);
      chk("sda_rel", 32'h0, sda_oe);
      chk("scl_rel", 32'h0, scl_oe);
      m.stop_c();
      $display("Test transmit done");
      // After the stop the count halts: no expiry in the 300 cycles that follow the transfer.
      wr(OFS_CTRL1, 8'h00);
      wr(OFS_TOC, 8'h80);
      m.start_c();
      m.put_byte(8'hB4, ack);
      apb(1'h0, OFS_DATA, 32'h0);
      m.put_byte(8'h69, ack);
      chk("ack3", 32'h0, ack);
      rd(OFS_DATA, 32'h69, "rx3");
      m.stop_c();
      repeat (300) @(posedge clk);
      rd(OFS_TOC, 32'h80, "no_expire");
      $display("Test stop done");
      wr(OFS_TOC, 8'h81);
      m.start_c();
      m.put_byte(8'hB4, ack);
      wr(OFS_INTERRUPT_CONTROL_ONE, 8'h01);
      wr(OFS_CTRL1, 8'h18);
      repeat (2) @(posedge clk);
      n = 0;
      while (irq !== 1'h1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk("to_time", 32'h1, n > 220 && n < 300);
      rd(OFS_TOC, 32'h41, "to_flag");
      rd(OFS_CTRL1, 32'h0, "ctrl1_rst");
      rd(OFS_ADDR, 32'h5A, "addr_kept", 32'h7F);
      rd(OFS_DATA, 32'h69, "data_kept");
      rd(OFS_CTRL0, 32'h1, "ctrl0_kept", 32'h1);
      chk("to_hold", 32'h0, scl_oe);
      rd(OFS_INTERRUPT_CONTROL_ONE, 32'h11, "to_irq");
      wr(OFS_TOC, 8'h00);
      rd(OFS_TOC, 32'h0, "flag_clr");
      m.stop_c();
      $display("Test timeout done");
      print_verdict();
   end
endmodule : i2c_slave_data_tb
